// [cmw_pkg.sv]
// Constants shared by the core memory write-cycle control block.
// Assumes a 50 MHz system clock; all delay-line taps become cycle counts here.
package cmw_pkg;
    // ------------------------------------------------------------------
    // Mode control codes (upper, lower)
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_READ = 2'h0; // Read with restore.
    localparam logic [1:0] MODE_READ_PAUSE = 2'h1; // Read, write withheld.
    localparam logic [1:0] MODE_WORD_WRITE = 2'h2; // Full-word write.
    localparam logic [1:0] MODE_BYTE_WRITE = 2'h3; // Byte write.
    // ------------------------------------------------------------------
    // Data layout
    // ------------------------------------------------------------------
    localparam int DATA_W = 16; // Word width in bits.
    localparam int HALF_W = 8; // Byte width in bits.
    localparam int ADDR_W = 10; // Default word address width.
    // ------------------------------------------------------------------
    // Delay-line taps, in ns, and derived clock counts
    // ------------------------------------------------------------------
    localparam int CLK_NS = 20; // Clock period.
    localparam int RESET_TAP_NS = 60; // Latch clear tap.
    localparam int SWITCH_TAP_NS = 200; // Cores switch at this tap.
    localparam int STROBE_TAP_NS = 240; // Sense strobe tap.
    localparam int PHASE_NS = 400; // Length of one timing phase.
    localparam int RESET_TAP_CYC = (RESET_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SWITCH_TAP_CYC = (SWITCH_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_TAP_CYC = (STROBE_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8; // Width of the timing counter.
endpackage

// [cmw_core_if.sv]
// Interface between the write-cycle controller and the core array model.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cmw_core_if #(parameter int AW = 10);
    logic [AW-1:0] addr; // Word address of the cycle.
    logic clearPulse; // Clearing read: cores forced to zero.
    logic writePulse; // Write: cores without inhibit become one.
    logic [15:0] inhibit; // Per-bit inhibit driver enables.
    logic [15:0] senseData; // Sensed old contents, registered.
    modport ctrl (output addr, clearPulse, writePulse, inhibit, input senseData);
    modport array (input addr, clearPulse, writePulse, inhibit, output senseData);
endinterface
`default_nettype wire

// [cmw_core_array.sv]
// Core array model: destructive read, inhibit-controlled write.
// Assumes one pulse at a time from the controller.
`timescale 1ns/1ns
`default_nettype none
module cmw_core_array
    import cmw_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    input wire logic clk,
    cmw_core_if.array core
);
    // Core storage, one word per location.
    logic [DATA_W-1:0] mem [DEPTH];
    // Registered sense data.
    logic [DATA_W-1:0] sense_ff;

    // ------------------------------------------------------------------
    // Array behaviour
    // ------------------------------------------------------------------
    // A clearing read reports old contents and leaves zeros behind.
    // A write sets every bit whose inhibit driver stays off.
    always_ff @(posedge clk) begin
        if (core.clearPulse) begin
            sense_ff <= mem[core.addr];
            mem[core.addr] <= '0;
        end else if (core.writePulse) begin
            mem[core.addr] <= mem[core.addr] | ~core.inhibit;
        end
    end

    assign core.senseData = sense_ff;
endmodule
`default_nettype wire

// [cmw_delay_chain.sv]
// Timing chain standing in for the delay line of one memory phase.
// Assumes start arrives only while the chain is idle.
`timescale 1ns/1ns
`default_nettype none
module cmw_delay_chain
    import cmw_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    output logic tReset,
    output logic tSwitch,
    output logic tStrobe,
    output logic tEnd,
    output logic tWidth
);
    // Tap counter and running flag.
    logic [CNT_W-1:0] cnt_ff;
    logic run_ff;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // The chain runs for one phase after each start, then stops.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (start) begin
            cnt_ff <= CNT_W'(1);
            run_ff <= 1'b1;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
            if (cnt_ff == CNT_W'(PHASE_CYC)) begin
                run_ff <= 1'b0;
            end
        end
    end

    // Tap decodes; each is a single-cycle pulse, except tWidth, which spans the whole phase.
    assign tReset = run_ff && (cnt_ff == CNT_W'(RESET_TAP_CYC));
    assign tSwitch = run_ff && (cnt_ff == CNT_W'(SWITCH_TAP_CYC));
    assign tStrobe = run_ff && (cnt_ff == CNT_W'(STROBE_TAP_CYC));
    assign tEnd = run_ff && (cnt_ff == CNT_W'(PHASE_CYC));
    assign tWidth = run_ff;
endmodule
`default_nettype wire

// [cmw_write_ctrl.sv]
// Write-cycle control of a 16-bit core memory on an async sync handshake.
// Assumes bus pins are asynchronous; each passes two flip-flops first.
// Operation
// - Full-word write stores sixteen bus bits.
// - Word write: clearing read, then write.
// - After read-pause, skip the clearing read.
// - Word-write clearing read: no clear, no strobe.
// - Bus data loads both latch halves.
// - Latch bits gated by half inhibit timing.
// - Byte write picks half by address bit.
// - Selected half: no clear/strobe, load data.
// - Unselected half: clear, strobe, no load.
// - Unselected half keeps old contents.
// - Byte write after read-pause skips read.
// - Slave sync after capture, drop after master.
// - Lockout flag blocks new cycles until done.
// - Latch zero drives inhibit; one does not.
`timescale 1ns/1ns
`default_nettype none
module cmw_write_ctrl
    import cmw_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DEPTH = 1024
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic masterSyncLine,
    input wire logic modeControlUpper,
    input wire logic modeControlLower,
    input wire logic byteSelectAddressBit,
    input wire logic [AW-1:0] wordAddress,
    input wire logic [DATA_W-1:0] busDataIn,
    output logic slaveSyncLine,
    output logic [DATA_W-1:0] busDataOut,
    output logic busDataDrive,
    output logic cycleLockoutFlag
);
    // ------------------------------------------------------------------
    // Types and declarations
    // ------------------------------------------------------------------
    // One-hot sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, // Waiting for master sync.
        ST_START = 5'h02, // Chain start issued.
        ST_READ = 5'h04, // Clearing read phase.
        ST_WRITE = 5'h08, // Inhibit-controlled write phase.
        ST_DONE = 5'h10 // Cycle over, lockout released.
    } cmw_state_e;

    cmw_state_e state_ff; // Sequencer state.
    logic msyncMeta_ff, msync_ff; // Master sync synchroniser.
    logic [1:0] modeMeta_ff, modeS_ff; // Mode synchroniser.
    logic selMeta_ff, selS_ff; // Byte select synchroniser.
    logic [AW-1:0] addrMeta_ff, addrS_ff; // Address synchroniser.
    logic [DATA_W-1:0] dataMeta_ff, dataS_ff; // Data synchroniser.
    logic [1:0] mode_ff; // Mode of the running cycle.
    logic sel_ff; // Byte select of the running cycle.
    logic [AW-1:0] addr_ff; // Address of the running cycle.
    logic pause_ff; // Last cycle was a read-pause.
    logic lockout_ff; // Cycle lockout flag.
    logic ssync_ff; // Slave sync.
    logic inWriteSeen_ff; // Write already acknowledged in this cycle.
    logic startChain_ff; // Start pulse to the timing chain.
    logic inWrite_ff; // Chain is running a write phase.
    logic [DATA_W-1:0] latch_ff; // Memory data latch.
    logic [DATA_W-1:0] dout_ff; // Bus output data.
    logic dataDrive_ff; // Bus output enable.
    logic tReset, tSwitch, tStrobe, tEnd, tWidth; // Chain taps.
    logic goNew; // A new transaction may begin.
    logic [1:0] senseHalf; // Halves that are cleared and strobed.
    logic [1:0] loadHalf; // Halves that take bus data.
    logic [1:0] inhTiming; // Low and high half inhibit timing.

    cmw_core_if #(.AW(AW)) core();

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Halves cleared and strobed in the read phase, bit 1 is the high half.
    function automatic logic [1:0] senseMask(input logic [1:0] m, input logic s);
        case (m)
            MODE_READ, MODE_READ_PAUSE: senseMask = 2'h3;
            MODE_WORD_WRITE: senseMask = 2'h0;
            MODE_BYTE_WRITE: senseMask = s ? 2'h1 : 2'h2;
            default: senseMask = 2'h0;
        endcase
    endfunction

    // Halves loaded from the bus when the write is taken.
    function automatic logic [1:0] loadMask(input logic [1:0] m, input logic s);
        case (m)
            MODE_WORD_WRITE: loadMask = 2'h3;
            MODE_BYTE_WRITE: loadMask = s ? 2'h2 : 2'h1;
            default: loadMask = 2'h0;
        endcase
    endfunction

    // True when the mode is one of the two write transactions.
    function automatic logic isWrite(input logic [1:0] m);
        isWrite = (m == MODE_WORD_WRITE) || (m == MODE_BYTE_WRITE);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Every bus pin passes two flip-flops; only the second is read.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msyncMeta_ff <= 1'b0;
            msync_ff <= 1'b0;
            modeMeta_ff <= 2'h0;
            modeS_ff <= 2'h0;
            selMeta_ff <= 1'b0;
            selS_ff <= 1'b0;
            addrMeta_ff <= '0;
            addrS_ff <= '0;
            dataMeta_ff <= '0;
            dataS_ff <= '0;
        end else begin
            msyncMeta_ff <= masterSyncLine;
            msync_ff <= msyncMeta_ff;
            modeMeta_ff <= {modeControlUpper, modeControlLower};
            modeS_ff <= modeMeta_ff;
            selMeta_ff <= byteSelectAddressBit;
            selS_ff <= selMeta_ff;
            addrMeta_ff <= wordAddress;
            addrS_ff <= addrMeta_ff;
            dataMeta_ff <= busDataIn;
            dataS_ff <= dataMeta_ff;
        end
    end

    // A new cycle needs master sync, a free lockout and a released slave sync.
    assign goNew = (state_ff == ST_IDLE) && msync_ff && !lockout_ff && !ssync_ff;

    // Sense mask of the running cycle; load mask from the synchronised pins.
    assign senseHalf = senseMask(mode_ff, sel_ff);
    assign loadHalf = loadMask(modeS_ff, selS_ff);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Steps through an optional clearing read and an optional write phase.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            startChain_ff <= 1'b0;
            inWrite_ff <= 1'b0;
        end else begin
            startChain_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (goNew) begin
                        state_ff <= ST_START;
                        startChain_ff <= 1'b1;
                        // A write after read-pause goes straight to writing.
                        inWrite_ff <= isWrite(modeS_ff) && pause_ff;
                    end
                end
                ST_START: begin
                    state_ff <= inWrite_ff ? ST_WRITE : ST_READ;
                end
                ST_READ: begin
                    if (tEnd) begin
                        if (mode_ff == MODE_READ_PAUSE) begin
                            // The write phase is withheld after a read-pause.
                            state_ff <= ST_DONE;
                        end else begin
                            // Clearing read done; follow with the write phase.
                            state_ff <= ST_START;
                            startChain_ff <= 1'b1;
                            inWrite_ff <= 1'b1;
                        end
                    end
                end
                ST_WRITE: begin
                    if (tEnd) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_ff <= ST_IDLE;
                    inWrite_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_IDLE;
                    inWrite_ff <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Cycle capture and lockout
    // ------------------------------------------------------------------
    // Mode, byte select and address are held for the whole cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= MODE_READ;
            sel_ff <= 1'b0;
            addr_ff <= '0;
        end else if (goNew) begin
            mode_ff <= modeS_ff;
            sel_ff <= selS_ff;
            addr_ff <= addrS_ff;
        end
    end

    // Lockout is set as a cycle starts and cleared only when it is over.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lockout_ff <= 1'b0;
        end else if (goNew) begin
            lockout_ff <= 1'b1;
        end else if (state_ff == ST_DONE) begin
            lockout_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pause flag
    // ------------------------------------------------------------------
    // Set at the strobe of a read-pause; cleared when the following write
    // has been acknowledged and master sync drops. The master is relied on
    // to make that following transaction a write.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pause_ff <= 1'b0;
        end else if (state_ff == ST_READ && tStrobe && mode_ff == MODE_READ_PAUSE) begin
            pause_ff <= 1'b1;
        end else if (ssync_ff && !msync_ff && isWrite(mode_ff)) begin
            pause_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Slave sync
    // ------------------------------------------------------------------
    // A write acknowledges once bus data is in the latch; a read once the
    // strobe has filled it. Slave sync falls after master sync is released.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ssync_ff <= 1'b0;
        end else if (state_ff == ST_START && isWrite(mode_ff) && !ssync_ff
                     && lockout_ff && !inWriteSeen_ff) begin
            ssync_ff <= 1'b1;
        end else if (state_ff == ST_READ && tStrobe && !isWrite(mode_ff)) begin
            ssync_ff <= 1'b1;
        end else if (ssync_ff && !msync_ff) begin
            ssync_ff <= 1'b0;
        end
    end

    // Marks that this cycle has already been acknowledged once.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inWriteSeen_ff <= 1'b0;
        end else if (goNew) begin
            inWriteSeen_ff <= 1'b0;
        end else if (ssync_ff) begin
            inWriteSeen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Memory data latch
    // ------------------------------------------------------------------
    // Bus data enters the loaded halves as the write is taken. During the
    // read phase, sensed halves are cleared at the reset tap and the old
    // contents are strobed in; other halves are left untouched.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_ff <= '0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (goNew && loadHalf[h]) begin
                    latch_ff[h*HALF_W +: HALF_W] <= dataS_ff[h*HALF_W +: HALF_W];
                end else if (state_ff == ST_READ && senseHalf[h] && tReset) begin
                    latch_ff[h*HALF_W +: HALF_W] <= '0;
                end else if (state_ff == ST_READ && senseHalf[h] && tStrobe) begin
                    latch_ff[h*HALF_W +: HALF_W] <= core.senseData[h*HALF_W +: HALF_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Core drive
    // ------------------------------------------------------------------
    // Both halves share one inhibit timing window during the write phase.
    assign inhTiming = {2{(state_ff == ST_WRITE) && tWidth}};
    assign core.addr = addr_ff;
    assign core.clearPulse = (state_ff == ST_READ) && tSwitch;
    assign core.writePulse = (state_ff == ST_WRITE) && tSwitch;
    // A zero latch bit inside the window turns its inhibit driver on.
    assign core.inhibit = {{HALF_W{inhTiming[1]}}, {HALF_W{inhTiming[0]}}}
                          & ~latch_ff;

    // ------------------------------------------------------------------
    // Read data output
    // ------------------------------------------------------------------
    // Read data is driven onto the bus while slave sync answers a read.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dout_ff <= '0;
            dataDrive_ff <= 1'b0;
        end else begin
            dout_ff <= latch_ff;
            dataDrive_ff <= ssync_ff && !isWrite(mode_ff);
        end
    end

    // ------------------------------------------------------------------
    // Submodules and outputs
    // ------------------------------------------------------------------
    cmw_delay_chain u_chain (
        .clk(clk),
        .reset_n(reset_n),
        .start(startChain_ff),
        .tReset(tReset),
        .tSwitch(tSwitch),
        .tStrobe(tStrobe),
        .tEnd(tEnd),
        .tWidth(tWidth)
    );

    cmw_core_array #(.DEPTH(DEPTH)) u_array (
        .clk(clk),
        .core(core.array)
    );

    assign slaveSyncLine = ssync_ff;
    assign busDataOut = dout_ff;
    assign busDataDrive = dataDrive_ff;
    assign cycleLockoutFlag = lockout_ff;
endmodule
`default_nettype wire

// [cmw_write_ctrl_monitor.sv]
// Checker of the write-cycle controller's handshake and lockout pins.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module cmw_write_ctrl_monitor
    import cmw_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic masterSyncLine,
    input wire logic modeControlUpper,
    input wire logic slaveSyncLine,
    input wire logic busDataDrive,
    input wire logic cycleLockoutFlag
);
    // ------------------------------------------------------------------
    // Handshake and lockout properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // A write is acknowledged as soon as its data sits in the latch.
    write_ack_a: assert property (
        $rose(cycleLockoutFlag) && modeControlUpper |-> ##[1:3] slaveSyncLine)
        else $error("write not acknowledged in time");
    // Slave sync is released shortly after the master lets go.
    ack_release_a: assert property (
        $fell(masterSyncLine) |-> ##[1:4] !slaveSyncLine)
        else $error("slave sync held after master release");
    // Slave sync stands while master sync stands.
    ack_hold_a: assert property (
        slaveSyncLine && masterSyncLine |=> slaveSyncLine)
        else $error("slave sync dropped early");
    // Slave sync only answers a live request.
    ack_cause_a: assert property (
        $rose(slaveSyncLine) |-> masterSyncLine)
        else $error("slave sync without master sync");
    // The lockout holds for at least 8 clocks and then ends.
    lock_min_a: assert property (
        $rose(cycleLockoutFlag) |-> cycleLockoutFlag[*8])
        else $error("lockout too short");
    lock_end_a: assert property (
        $rose(cycleLockoutFlag) |-> ##[15:80] !cycleLockoutFlag)
        else $error("lockout never ends");
    // Read data is never driven for a write.
    drive_read_a: assert property (
        $rose(busDataDrive) |-> !modeControlUpper)
        else $error("data driven during a write");
    drive_off_a: assert property (
        $fell(slaveSyncLine) |-> ##[0:2] !busDataDrive)
        else $error("data still driven after release");
endmodule
bind cmw_write_ctrl cmw_write_ctrl_monitor mon (.clk(clk), .reset_n(reset_n),
    .masterSyncLine(masterSyncLine), .modeControlUpper(modeControlUpper),
    .slaveSyncLine(slaveSyncLine), .busDataDrive(busDataDrive),
    .cycleLockoutFlag(cycleLockoutFlag));
`default_nettype wire

// [cmw_bus_master.sv]
// Bus master model that runs transfers into the write-cycle controller.
// Assumes the controller synchronises every pin it samples.
`timescale 1ns/1ns
`default_nettype none
module cmw_bus_master
    import cmw_pkg::*;
(
    input wire logic clk,
    input wire logic slaveSyncLine,
    input wire logic busDataDrive,
    input wire logic [DATA_W-1:0] busDataOut,
    input wire logic cycleLockoutFlag,
    output logic masterSyncLine,
    output logic [1:0] mode,
    output logic byteSel,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dataIn
);
    // Idle pins at time zero.
    initial begin
        masterSyncLine = 1'b0;
        mode = MODE_READ;
        byteSel = 1'b0;
        addr = 10'h000;
        dataIn = 16'h0000;
    end
    // One transfer; hold slows the release, hasty skips the lockout wait.
    // Master sync is always let go first, as the four-phase handshake asks.
    task automatic xfer(input logic [1:0] m, input logic [ADDR_W-1:0] a, input logic s,
        input logic [DATA_W-1:0] d, input int hold, input bit hasty,
        output logic [DATA_W-1:0] q, output int lat);
        int n;
        n = 0;
        lat = 0;
        while (((!hasty && cycleLockoutFlag) || slaveSyncLine) && n < 400) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        mode <= m;
        addr <= a;
        byteSel <= s;
        dataIn <= d;
        @(posedge clk);
        masterSyncLine <= 1'b1;
        // A write ends at slave sync, a read once data is driven.
        while (!(m[1] ? slaveSyncLine : busDataDrive) && lat < 400) begin
            @(posedge clk);
            lat++;
        end
        q = busDataOut;
        repeat (hold) @(posedge clk);
        masterSyncLine <= 1'b0;
        dataIn <= ~d;
    endtask
endmodule
`default_nettype wire

// [cmw_write_ctrl_tb_top.sv]
// Self-checking bench of the write-cycle controller.
// Assumes the bus master model drives every request pin.
`timescale 1ns/1ns
`default_nettype none
module cmw_write_ctrl_tb_top
    import cmw_pkg::*;
;
    logic clk;
    logic reset_n;
    logic mSync, ssync, drive, lock, sel;
    logic [1:0] mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din, dout, q;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int lat, lockRun = 0, lastLock = 0;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
    initial clk = 1'b0;
    always #10 clk = ~clk;
    cmw_write_ctrl dut (.clk(clk), .reset_n(reset_n), .masterSyncLine(mSync),
        .modeControlUpper(mode[1]), .modeControlLower(mode[0]), .byteSelectAddressBit(sel),
        .wordAddress(addr), .busDataIn(din), .slaveSyncLine(ssync), .busDataOut(dout),
        .busDataDrive(drive), .cycleLockoutFlag(lock));
    cmw_bus_master bm (.clk(clk), .slaveSyncLine(ssync), .busDataDrive(drive),
        .busDataOut(dout), .cycleLockoutFlag(lock), .masterSyncLine(mSync), .mode(mode),
        .byteSel(sel), .addr(addr), .dataIn(din));
    // Verdict and end of run.
    task results;
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cycle ceiling and length of the last lockout.
    always @(posedge clk) begin
        cycles++;
        if (lock) lockRun <= lockRun + 1;
        else begin
            if (lockRun != 0) lastLock <= lockRun;
            lockRun <= 0;
        end
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    // Plain transfer through the master model.
    task automatic rw(input logic [1:0] m, input logic [ADDR_W-1:0] a, input logic s,
        input logic [DATA_W-1:0] d);
        bm.xfer(m, a, s, d, 0, 1'b0, q, lat);
        `CHK(lat < 400, 1'b1)
    endtask
    // Word writes of several patterns, each read back twice.
    task automatic word_write;
        logic [DATA_W-1:0] pat [3] = '{16'ha5c3, 16'hffff, 16'h0000};
        foreach (pat[i]) begin
            bm.xfer(MODE_WORD_WRITE, 10'h001, 1'b0, pat[i], 6, 1'b0, q, lat);
            `CHK(lat < 400, 1'b1)
            rw(MODE_READ, 10'h001, 1'b0, 16'h0000);
            `CHK(lastLock >= 2 * PHASE_CYC, 1'b1)
            `CHK(q, pat[i])
            rw(MODE_READ, 10'h001, 1'b0, 16'h0000);
            `CHK(q, pat[i])
        end
    endtask
    // Byte writes to both halves at the top address.
    task automatic byte_write;
        rw(MODE_WORD_WRITE, 10'h3ff, 1'b0, 16'h1234);
        rw(MODE_BYTE_WRITE, 10'h3ff, 1'b0, 16'hffab);
        rw(MODE_READ, 10'h3ff, 1'b0, 16'h0000);
        `CHK(q, 16'h12ab)
        rw(MODE_BYTE_WRITE, 10'h3ff, 1'b1, 16'hcdff);
        rw(MODE_READ, 10'h3ff, 1'b0, 16'h0000);
        `CHK(q, 16'hcdab)
    endtask
    // Read-pause followed by word and byte writes.
    task automatic pause_write;
        rw(MODE_WORD_WRITE, 10'h200, 1'b0, 16'h5a5a);
        rw(MODE_READ_PAUSE, 10'h200, 1'b0, 16'h0000);
        `CHK(q, 16'h5a5a)
        rw(MODE_WORD_WRITE, 10'h200, 1'b0, 16'h0f0f);
        rw(MODE_READ, 10'h200, 1'b0, 16'h0000);
        `CHK(lastLock < 2 * PHASE_CYC, 1'b1)
        `CHK(q, 16'h0f0f)
        rw(MODE_READ_PAUSE, 10'h200, 1'b0, 16'h0000);
        rw(MODE_BYTE_WRITE, 10'h200, 1'b1, 16'h7711);
        rw(MODE_READ, 10'h200, 1'b0, 16'h0000);
        `CHK(lastLock < 2 * PHASE_CYC, 1'b1)
        `CHK(q, 16'h770f)
        rw(MODE_READ_PAUSE, 10'h200, 1'b0, 16'h0000);
        rw(MODE_BYTE_WRITE, 10'h200, 1'b0, 16'h1122);
        rw(MODE_READ, 10'h200, 1'b0, 16'h0000);
        `CHK(q, 16'h7722)
    endtask
    // A read raised during a write's lockout must wait for it.
    task automatic lockout;
        rw(MODE_WORD_WRITE, 10'h005, 1'b0, 16'hbeef);
        bm.xfer(MODE_READ, 10'h005, 1'b0, 16'h0000, 0, 1'b1, q, lat);
        `CHK(lat > PHASE_CYC, 1'b1)
        `CHK(lat < 400, 1'b1)
        `CHK(q, 16'hbeef)
    endtask
    // Main sequence.
    initial begin
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        word_write();
        byte_write();
        pause_write();
        lockout();
        results();
    end
endmodule
`default_nettype wire
